/* core/rtio_pkg.sv */
// Notes on behaviour
// - A strobed event write pulses the event number 0 to 15 toward the controller.
// - Event write view: bit 5 is the strobe, bits 3:0 the vector, rest reserved.
// - Event outputs of both cores are ORed into one shared event output.
// - Core events 0 to 15 appear as system events 16 to 31.
// - Reading the event register returns host interrupt 1 in bit 31, 0 in bit 30.
// - In direct input mode, reading the event register returns the 30 input signals in bits 29:0.
// - Every output register write drives the 32 output signals in direct output mode, bits 31:2 in shift mode.
// - Direct input feeds bits 29:0; direct output drives bits 31:0 unchanged.
// - Input modes are direct, parallel capture or shift; only one is active.
// - Parallel capture latches bits 15:0 on the chosen edge of input bit 16.
// - Input shift samples bit 0 into a 28-bit register at the shift rate.
// - Input shift shows the shift counter flag in bit 28, start bit in 29.
// - Shift rate comes from two cascaded dividers, each 1 to 16 in half steps.
// - Output shift drives data on bit 0 at each rising edge of clock on bit 1.
// - One serializer; output bits 29 and 30 load shadows, bit 31 enables shifting.
package rtio_pkg;
  localparam int WORD_W = 32;
  localparam int GPI_W = 30;
  localparam int SIN_W = 28;
  localparam int SO_W = 16;
  localparam int EVT_N = 16;
  localparam int DIV_W = 6;
  // Write view of the event register
  localparam int EVT_VEC_LSB = 0;
  localparam int EVT_VEC_W = 4;
  localparam int EVT_VALID_BIT = 5;
  localparam int SYS_EVT_BASE = 16;
  // Read view of the event register
  localparam int HOST_IRQ1_BIT = 31;
  localparam int HOST_IRQ0_BIT = 30;
  localparam int DIRECT_IN_W = 17;
  localparam int PAR_W = 16;
  localparam int PAR_CLK_BIT = 16;
  localparam int CNT16_BIT = 28;
  localparam int SB_BIT = 29;
  localparam logic [4:0] CNT16_MARK = 5'h10;
  localparam logic [4:0] SIN_LAST = 5'h1B;
  // Output word control bits
  localparam int SO_DATA_BIT = 0;
  localparam int SO_CLK_BIT = 1;
  localparam int LOAD_SH0_BIT = 29;
  localparam int LOAD_SH1_BIT = 30;
  localparam int SHIFT_EN_BIT = 31;
  localparam logic [3:0] SO_LAST = 4'hF;
  // Divider in half steps: 2 means 1.0, 32 means 16.0
  localparam logic [DIV_W-1:0] DIV_HALF_MIN = 6'h02;
  localparam logic [DIV_W-1:0] DIV_HALF_MAX = 6'h20;
  localparam logic [DIV_W-1:0] DIV_STEP = 6'h02;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  typedef enum logic [1:0] {IN_DIRECT, IN_PARALLEL, IN_SHIFT} rtio_in_mode_t;
  typedef enum logic {OUT_DIRECT, OUT_SHIFT} rtio_out_mode_t;
endpackage

/* core/rtio_frac_div.sv */
module rtio_frac_div (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Rate
  input wire logic en_i,
  input wire logic [rtio_pkg::DIV_W-1:0] div_half_i,
  output logic tick_o
);
  typedef struct packed {
    logic [rtio_pkg::DIV_W:0] acc;
    logic tick;
  } rtio_div_st_t;
  rtio_div_st_t st_r;
  rtio_div_st_t st_nxt;
  logic [rtio_pkg::DIV_W:0] lim;
  logic [rtio_pkg::DIV_W:0] sum;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    // Out-of-range settings are clamped so the divider never stalls
    if (div_half_i < rtio_pkg::DIV_HALF_MIN)
      lim = {1'b0, rtio_pkg::DIV_HALF_MIN};
    else if (div_half_i > rtio_pkg::DIV_HALF_MAX)
      lim = {1'b0, rtio_pkg::DIV_HALF_MAX};
    else
      lim = {1'b0, div_half_i};
    sum = st_r.acc + {1'b0, rtio_pkg::DIV_STEP};
    if (en_i)
    begin
      // Half-step division: two per input tick, one output per limit
      if (sum >= lim)
      begin
        st_nxt.acc = sum - lim;
        st_nxt.tick = 1'b1;
      end
      else
        st_nxt.acc = sum;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_o = st_r.tick;
endmodule // rtio_frac_div

/* core/rtio_fifo2.sv */
module rtio_fifo2 (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [rtio_pkg::SIN_W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [rtio_pkg::SIN_W-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][rtio_pkg::SIN_W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } rtio_fifo_st_t;
  rtio_fifo_st_t st_r;
  rtio_fifo_st_t st_nxt;
  logic push;
  logic pop;

  always_comb
  begin
    st_nxt = st_r;
    push = in_valid_i && (st_r.cnt != 2'h2);
    pop = out_ready_i && (st_r.cnt != 2'h0);
    if (push)
    begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp = ~st_r.wp;
    end
    if (pop)
      st_nxt.rp = ~st_r.rp;
    if (push && !pop)
      st_nxt.cnt = st_r.cnt + 2'h1;
    else if (pop && !push)
      st_nxt.cnt = st_r.cnt - 2'h1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign in_ready_o = (st_r.cnt != 2'h2);
  assign out_valid_o = (st_r.cnt != 2'h0);
  assign out_data_o = st_r.mem[st_r.rp];
endmodule // rtio_fifo2

/* core/rtio_io_port.sv */
module rtio_io_port (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Core register access
  input wire logic out_wr_i,
  input wire logic evt_wr_i,
  input wire logic [rtio_pkg::WORD_W-1:0] wr_data_i,
  input wire logic rd_i,
  output logic [rtio_pkg::WORD_W-1:0] rd_data_o,
  // Subsystem configuration
  input wire rtio_pkg::rtio_in_mode_t in_mode_i,
  input wire rtio_pkg::rtio_out_mode_t out_mode_i,
  input wire logic cap_negedge_i,
  input wire logic [rtio_pkg::DIV_W-1:0] div0_half_i,
  input wire logic [rtio_pkg::DIV_W-1:0] div1_half_i,
  // Pins
  input wire logic [rtio_pkg::GPI_W-1:0] gpi_i,
  input wire logic [1:0] host_irq_inputs_i,
  output logic [rtio_pkg::WORD_W-1:0] gpo_o,
  // Events
  input wire logic [rtio_pkg::EVT_N-1:0] peer_event_i,
  output logic [rtio_pkg::WORD_W-1:0] sys_event_o,
  // Shift-in word stream
  output logic sin_valid_o,
  output logic [rtio_pkg::SIN_W-1:0] sin_data_o,
  input wire logic sin_ready_i
);
  typedef struct packed {
    logic [rtio_pkg::WORD_W-1:0] out_word;
    logic [rtio_pkg::EVT_N-1:0] evt;
    logic [rtio_pkg::WORD_W-1:0] rd_data;
    logic par_clk_prev;
    logic [rtio_pkg::PAR_W-1:0] par_data;
    logic [rtio_pkg::SIN_W-1:0] sin_sr;
    logic [4:0] sin_cnt;
    logic sin_run;
    logic cnt16;
    logic start_bit_flag;
    logic [rtio_pkg::SO_W-1:0] shadow0;
    logic [rtio_pkg::SO_W-1:0] shadow1;
    logic [rtio_pkg::SO_W-1:0] so_sr;
    logic [3:0] so_cnt;
    logic so_sel;
    logic so_clk;
    logic so_dat;
  } rtio_st_t;
  rtio_st_t st_r;
  rtio_st_t st_nxt;

  logic tick0;
  logic tick1;
  logic push;
  logic push_ready;
  logic [rtio_pkg::SIN_W-1:0] push_data;
  logic par_edge;
  logic [rtio_pkg::EVT_VEC_W-1:0] vec;
  logic [rtio_pkg::WORD_W-1:0] view;

  // Cascaded shift-rate dividers
  rtio_frac_div u_div0 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .en_i(1'b1),
    .div_half_i(div0_half_i),
    .tick_o(tick0)
  );

  rtio_frac_div u_div1 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .en_i(tick0),
    .div_half_i(div1_half_i),
    .tick_o(tick1)
  );

  // Two-entry buffer so a stalled receiver loses no shifted word
  rtio_fifo2 u_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .in_valid_i(push),
    .in_data_i(push_data),
    .in_ready_o(push_ready),
    .out_valid_o(sin_valid_o),
    .out_data_o(sin_data_o),
    .out_ready_i(sin_ready_i)
  );

  always_comb
  begin
    st_nxt = st_r;
    push = 1'b0;
    push_data = {gpi_i[0], st_r.sin_sr[rtio_pkg::SIN_W-1:1]};
    vec = wr_data_i[rtio_pkg::EVT_VEC_LSB +: rtio_pkg::EVT_VEC_W];

    // Event pulse lasts one cycle; only strobe and vector bits matter
    st_nxt.evt = '0;
    if (evt_wr_i && wr_data_i[rtio_pkg::EVT_VALID_BIT])
      st_nxt.evt[vec] = 1'b1;

    // Output word and shadow loads
    if (out_wr_i)
    begin
      st_nxt.out_word = wr_data_i;
      if (wr_data_i[rtio_pkg::LOAD_SH0_BIT])
        st_nxt.shadow0 = wr_data_i[rtio_pkg::SO_W-1:0];
      if (wr_data_i[rtio_pkg::LOAD_SH1_BIT])
        st_nxt.shadow1 = wr_data_i[rtio_pkg::SO_W-1:0];
    end

    // Parallel capture on the selected edge of input bit 16
    st_nxt.par_clk_prev = gpi_i[rtio_pkg::PAR_CLK_BIT];
    if (cap_negedge_i)
      par_edge = st_r.par_clk_prev && !gpi_i[rtio_pkg::PAR_CLK_BIT];
    else
      par_edge = !st_r.par_clk_prev && gpi_i[rtio_pkg::PAR_CLK_BIT];
    if (in_mode_i == rtio_pkg::IN_PARALLEL && par_edge)
      st_nxt.par_data = gpi_i[rtio_pkg::PAR_W-1:0];

    // A read clears the shift flags; a set in the same cycle wins below
    if (rd_i)
    begin
      st_nxt.cnt16 = 1'b0;
      st_nxt.start_bit_flag = 1'b0;
    end

    // Shift-in: wait for a low start bit, then take 28 samples of bit 0.
    // A full buffer holds the shifter, so samples are skipped, not words.
    if (in_mode_i != rtio_pkg::IN_SHIFT)
    begin
      st_nxt.sin_run = 1'b0;
      st_nxt.sin_cnt = '0;
    end
    else if (tick1 && push_ready)
    begin
      if (!st_r.sin_run)
      begin
        if (!gpi_i[0])
        begin
          st_nxt.sin_run = 1'b1;
          st_nxt.sin_cnt = '0;
          st_nxt.start_bit_flag = 1'b1;
        end
      end
      else
      begin
        st_nxt.sin_sr = push_data;
        st_nxt.sin_cnt = st_r.sin_cnt + 5'h01;
        if (st_r.sin_cnt + 5'h01 == rtio_pkg::CNT16_MARK)
          st_nxt.cnt16 = 1'b1;
        if (st_r.sin_cnt == rtio_pkg::SIN_LAST)
        begin
          push = 1'b1;
          st_nxt.sin_run = 1'b0;
          st_nxt.sin_cnt = '0;
        end
      end
    end

    // Shift-out: clock toggles per tick, data changes with its rising edge
    if (out_mode_i != rtio_pkg::OUT_SHIFT || !st_r.out_word[rtio_pkg::SHIFT_EN_BIT])
    begin
      st_nxt.so_clk = 1'b0;
      st_nxt.so_cnt = '0;
      st_nxt.so_sel = 1'b0;
      st_nxt.so_sr = st_nxt.shadow0;
    end
    else if (tick1)
    begin
      st_nxt.so_clk = !st_r.so_clk;
      if (!st_r.so_clk)
      begin
        st_nxt.so_dat = st_r.so_sr[0];
        st_nxt.so_sr = st_r.so_sr >> 1;
        st_nxt.so_cnt = st_r.so_cnt + 4'h1;
        if (st_r.so_cnt == rtio_pkg::SO_LAST)
        begin
          // Ping-pong between the shadows so software can reload the idle one
          st_nxt.so_sel = !st_r.so_sel;
          st_nxt.so_sr = st_r.so_sel ? st_nxt.shadow0 : st_nxt.shadow1;
        end
      end
    end

    // Read view of the event register
    view = '0;
    view[rtio_pkg::HOST_IRQ1_BIT] = host_irq_inputs_i[1];
    view[rtio_pkg::HOST_IRQ0_BIT] = host_irq_inputs_i[0];
    unique case (in_mode_i)
      rtio_pkg::IN_DIRECT:
      begin
        view[rtio_pkg::GPI_W-1:0] = gpi_i;
      end
      rtio_pkg::IN_PARALLEL:
      begin
        view[rtio_pkg::GPI_W-1:0] = gpi_i;
        view[rtio_pkg::PAR_W-1:0] = st_r.par_data;
      end
      rtio_pkg::IN_SHIFT:
      begin
        view[rtio_pkg::SIN_W-1:0] = st_r.sin_sr;
        view[rtio_pkg::CNT16_BIT] = st_r.cnt16;
        view[rtio_pkg::SB_BIT] = st_r.start_bit_flag;
      end
      default:
      begin
        view[rtio_pkg::GPI_W-1:0] = gpi_i;
      end
    endcase
    if (rd_i)
      st_nxt.rd_data = view;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Output pins
  always_comb
  begin
    gpo_o = st_r.out_word;
    if (out_mode_i == rtio_pkg::OUT_SHIFT)
    begin
      gpo_o[rtio_pkg::SO_DATA_BIT] = st_r.so_dat;
      gpo_o[rtio_pkg::SO_CLK_BIT] = st_r.so_clk;
    end
  end

  // Own events ORed with the other core's, placed at system events 16 to 31
  assign sys_event_o = {st_r.evt | peer_event_i, {rtio_pkg::SYS_EVT_BASE{1'b0}}};
  assign rd_data_o = st_r.rd_data;
endmodule // rtio_io_port

/* tb/rtio_io_port_chk.sv */
module rtio_io_port_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Watched ports
  input wire logic out_wr_i,
  input wire logic evt_wr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire rtio_pkg::rtio_in_mode_t in_mode_i,
  input wire logic [29:0] gpi_i,
  input wire logic [1:0] host_irq_inputs_i,
  input wire logic [31:0] gpo_o,
  input wire logic [15:0] peer_event_i,
  input wire logic [31:0] sys_event_o,
  input wire logic sin_valid_o,
  input wire logic [27:0] sin_data_o,
  input wire logic sin_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  // Peer bits masked, so a peer pulse is not taken for a stray pulse of ours; a shared number can hide one
  logic [15:0] own;
  assign own = sys_event_o[31:16] & ~peer_event_i;
  property word_held;
    sin_valid_o && !sin_ready_i |=> sin_valid_o && $stable(sin_data_o);
  endproperty
  a_evt_pulse: assert property (
    evt_wr_i && wr_data_i[5] |=> sys_event_o[16 + $past(wr_data_i[3:0])])
    else $error("event pulse missing");
  a_evt_quiet: assert property (
    !(evt_wr_i && wr_data_i[5]) |=> own == 16'h0000) else $error("stray pulse");
  a_peer_or: assert property (
    (sys_event_o[31:16] & peer_event_i) == peer_event_i && sys_event_o[15:0] == 16'h0000)
    else $error("peer merge wrong");
  a_out_word: assert property (
    out_wr_i |=> gpo_o[31:2] == $past(wr_data_i[31:2])) else $error("output word wrong");
  a_out_hold: assert property (
    !out_wr_i |=> $stable(gpo_o[31:2])) else $error("output word moved");
  a_read_irq: assert property (
    rd_i |=> rd_data_o[31:30] == $past(host_irq_inputs_i)) else $error("irq bits wrong");
  a_read_pins: assert property (
    rd_i && in_mode_i == rtio_pkg::IN_DIRECT |=> rd_data_o[29:0] == $past(gpi_i))
    else $error("pin bits wrong");
  a_word_held: assert property (word_held) else $error("stalled word changed");
  c_evt: cover property (evt_wr_i && wr_data_i[5]);
  c_stall: cover property (sin_valid_o && !sin_ready_i ##1 sin_ready_i);
  c_take: cover property (sin_valid_o && sin_ready_i);
endmodule // rtio_io_port_chk
bind rtio_io_port rtio_io_port_chk rtio_io_port_chk_inst (.core_clk_i, .srst_i, .out_wr_i,
  .evt_wr_i, .wr_data_i, .rd_i, .rd_data_o, .in_mode_i, .gpi_i, .host_irq_inputs_i, .gpo_o,
  .peer_event_i, .sys_event_o, .sin_valid_o, .sin_data_o, .sin_ready_i);

/* tb/rtio_pin_model.sv */
module rtio_pin_model (
  // Clock
  input wire logic core_clk_i,
  // Word stream
  input wire logic sin_valid_i,
  input wire logic [27:0] sin_data_i,
  output logic sin_ready_o,
  // Bench control
  input wire logic stall_i,
  output int words_o,
  output logic [27:0] last_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  // Ready follows the stall request, so a stall can last any number of cycles
  assign sin_ready_o = !stall_i;
  assign words_o = cnt;
  always @(posedge core_clk_i)
  begin
    if (sin_valid_i && sin_ready_o)
    begin
      cnt <= cnt + 1;
      last_o <= sin_data_i;
    end
  end
endmodule // rtio_pin_model

/* tb/rt_core_io_event_port_test.sv */
module rt_core_io_event_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic out_wr_i = 1'h0;
  logic evt_wr_i = 1'h0;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic rd_i = 1'h0;
  logic [31:0] rd_data_o;
  rtio_pkg::rtio_in_mode_t in_mode_i = rtio_pkg::IN_DIRECT;
  rtio_pkg::rtio_out_mode_t out_mode_i = rtio_pkg::OUT_DIRECT;
  logic cap_negedge_i = 1'h0;
  logic [5:0] div0_half_i = 6'h02;
  logic [5:0] div1_half_i = 6'h02;
  logic [29:0] gpi_i = 30'h0000_0000;
  logic [1:0] host_irq_inputs_i = 2'h0;
  logic [31:0] gpo_o;
  logic [15:0] peer_event_i = 16'h0000;
  logic [31:0] sys_event_o;
  logic sin_valid_o;
  logic [27:0] sin_data_o;
  logic sin_ready_i;
  logic stall = 1'h1;
  int words;
  logic [27:0] last_w;
  int bad_count = 0;
  int checks_done = 0;
  always #5 core_clk_i = ~core_clk_i;
  rtio_io_port rtio_io_port_inst (.core_clk_i, .srst_i, .out_wr_i, .evt_wr_i, .wr_data_i, .rd_i,
    .rd_data_o, .in_mode_i, .out_mode_i, .cap_negedge_i, .div0_half_i, .div1_half_i, .gpi_i,
    .host_irq_inputs_i, .gpo_o, .peer_event_i, .sys_event_o, .sin_valid_o, .sin_data_o,
    .sin_ready_i);
  rtio_pin_model rtio_pin_model_inst (.core_clk_i, .sin_valid_i(sin_valid_o),
    .sin_data_i(sin_data_o), .sin_ready_o(sin_ready_i), .stall_i(stall), .words_o(words),
    .last_o(last_w));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic limit(input int n);
    if (n >= 400)
    begin
      chk(32'(n), 32'h0000_0000);
      complete_run();
    end
  endtask
  task automatic wr(input logic o, input logic [31:0] d);
    cyc(1);
    out_wr_i = o;
    evt_wr_i = !o;
    wr_data_i = d;
    cyc(1);
    out_wr_i = 1'h0;
    evt_wr_i = 1'h0;
  endtask
  task automatic rd(output logic [31:0] q);
    cyc(1);
    rd_i = 1'h1;
    cyc(1);
    rd_i = 1'h0;
    q = rd_data_o;
  endtask
  task automatic t_reset();
    srst_i = 1'h1;
    cyc(3);
    srst_i = 1'h0;
    chk(gpo_o, 32'h0000_0000);
    chk(sys_event_o | 32'(sin_valid_o), 32'h0000_0000);
    $display("reset done");
  endtask
  task automatic t_evt();
    // Back to back writes, reserved bits all set
    for (int v = 0; v < 17; v++)
    begin
      cyc(1);
      if (v > 0)
        chk(sys_event_o, 32'h0000_8000 << v);
      evt_wr_i = (v < 16);
      wr_data_i = 32'hFFFF_FFF0 | 32'(v);
    end
    cyc(1);
    chk(sys_event_o, 32'h0000_0000);
    wr(1'h0, 32'hFFFF_FFDF);
    chk(sys_event_o, 32'h0000_0000);
    peer_event_i = 16'h0100;
    wr(1'h0, 32'h0000_0023);
    chk(sys_event_o, 32'h0108_0000);
    peer_event_i = 16'h0000;
    $display("event done");
  endtask
  task automatic t_io();
    logic [31:0] q;
    wr(1'h1, 32'h5A5A_C3A5);
    chk(gpo_o, 32'h5A5A_C3A5);
    host_irq_inputs_i = 2'h2;
    gpi_i = 30'h2AAA_5555;
    rd(q);
    chk(q, 32'hAAAA_5555);
    chk(gpo_o, 32'h5A5A_C3A5);
    host_irq_inputs_i = 2'h1;
    gpi_i = 30'h1555_AAAA;
    rd(q);
    chk(q, 32'h5555_AAAA);
    $display("io done");
  endtask
  task automatic t_par();
    logic [31:0] q;
    in_mode_i = rtio_pkg::IN_PARALLEL;
    host_irq_inputs_i = 2'h0;
    gpi_i = 30'h0000_1234;
    cyc(2);
    gpi_i = 30'h0001_1234;
    cyc(2);
    gpi_i = 30'h0001_9999;
    rd(q);
    chk(q, 32'h0001_1234);
    cap_negedge_i = 1'h1;
    gpi_i = 30'h0001_7777;
    cyc(2);
    gpi_i = 30'h0000_7777;
    cyc(2);
    gpi_i = 30'h0001_5555;
    rd(q);
    chk(q, 32'h0001_7777);
    in_mode_i = rtio_pkg::IN_DIRECT;
    gpi_i = 30'h0000_0000;
    $display("capture done");
  endtask
  task automatic t_sin();
    int n;
    logic [31:0] q;
    in_mode_i = rtio_pkg::IN_SHIFT;
    // Start bit at the first tick, then one high sample leads the first word
    cyc(1);
    gpi_i[0] = 1'h1;
    cyc(1);
    gpi_i[0] = 1'h0;
    for (n = 0; n < 400 && sin_valid_o !== 1'h1; n++)
      cyc(1);
    limit(n);
    cyc(100);
    rd(q);
    chk(32'(q[31:28]), 32'h0000_0003);
    stall = 1'h0;
    cyc(1);
    stall = 1'h1;
    chk(32'(words) | 32'(sin_valid_o) << 4, 32'h0000_0011);
    chk(32'(last_w), 32'h0000_0001);
    in_mode_i = rtio_pkg::IN_DIRECT;
    stall = 1'h0;
    cyc(9);
    chk(32'(last_w) | 32'(sin_valid_o), 32'h0000_0000);
    $display("shift-in done");
  endtask
  task automatic t_sout();
    logic [16:0] b;
    logic p;
    int n;
    int k;
    int t;
    out_mode_i = rtio_pkg::OUT_SHIFT;
    div0_half_i = 6'h05;
    div1_half_i = 6'h04;
    wr(1'h1, 32'h2000_A5C3);
    wr(1'h1, 32'h4000_3C5A);
    wr(1'h1, 32'h8000_0000);
    k = 0;
    t = 0;
    for (n = 0; n < 400 && k < 17; n++)
    begin
      p = gpo_o[1];
      cyc(1);
      if (gpo_o[1] && !p)
      begin
        if (k == 1)
          chk(32'(n - t), 32'h0000_000A);
        b[k] = gpo_o[0];
        t = n;
        k++;
      end
    end
    limit(n);
    chk(32'(b), 32'h0000_A5C3);
    out_mode_i = rtio_pkg::OUT_DIRECT;
    wr(1'h1, 32'h0000_0000);
    chk(gpo_o, 32'h0000_0000);
    $display("shift-out done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_evt();
    t_io();
    t_par();
    t_sin();
    t_sout();
    wr(1'h1, 32'hFFFF_0003);
    t_reset();
    complete_run();
  end
endmodule // rt_core_io_event_port_test
